// ---- link_partner.sv ----
// far-side completer model, slow: one aligned block every fourth cycle
`timescale 1ns/1ps
module link_partner (
   input wire logic clk,
   input wire logic start,
   output logic rd_outstanding = 1'h0,
   output logic [3:0] blocks_left = 4'hf
);
   logic [1:0] gap = 2'h0;
   // start loads twelve blocks; the last block ends the read
   always @(posedge clk) begin
      gap <= gap + 2'h1;
      if (start) {rd_outstanding, blocks_left} <= 5'h1c;
      else if (rd_outstanding && gap == 2'h0)
         {rd_outstanding, blocks_left} <= {blocks_left != 4'h0, blocks_left - 4'h1};
   end
endmodule : link_partner

// ---- pacing_cfg.svh ----
// register offsets, field positions, reset values, the drive limit and the clock rate
`ifndef PACING_CFG_SVH
`define PACING_CFG_SVH
`define OFS_PACING 8'h68
`define OFS_PHY 8'h6c
`define RD_PACE_LSB 27
`define WR_FRAG_LSB 30
`define TIMER_LSB 0
`define EQ_LSB 3
`define CR_EN_BIT 7
`define CR_GAIN_LSB 8
`define SIGDET_LSB 10
`define CR_FILT_LSB 12
`define DEEMPH_EN_LSB 14
`define DEEMPH_BASE_LSB 18
`define LEVEL_BASE_LSB 23
`define DRIVE_LSB 28
`define RST_RD_PACE 3'h0
`define RST_WR_FRAG 2'h2
`define RST_TIMER 3'h2
`define RST_EQ 4'h2
`define RST_CR_EN 1'h0
`define RST_CR_GAIN 2'h2
`define RST_SIGDET 2'h1
`define RST_CR_FILT 2'h3
`define RST_DEEMPH_EN 4'h0
`define RST_DEEMPH_BASE 5'h0d
`define RST_LEVEL_BASE 5'h13
`define RST_DRIVE 3'h0
`define DRIVE_MAX 3'h4
`define CLK_MHZ 25
`endif

// ---- pacing_pkg.sv ----
// types shared by the pacing and phy tuning register bank
package pacing_pkg;
   typedef struct packed {
      logic [2:0] rd_pace;
      logic [1:0] wr_frag;
   } pacing_t;
   typedef struct packed {
      logic [2:0] drive;
      logic [4:0] level_base;
      logic [4:0] deemph_base;
      logic [3:0] deemph_en;
      logic [1:0] cr_filt;
      logic [1:0] sigdet;
      logic [1:0] cr_gain;
      logic cr_en;
      logic [3:0] eq;
      logic [2:0] timer;
   } phy_t;
   typedef enum logic [1:0] {idle, waiting, done} detect_state_t;
endpackage : pacing_pkg

// ---- tb.sv ----
// self-checking bench for the pacing and phy tuning bank
`timescale 1ns/1ps
module tb;
   logic clk = 0, resetn = 0, wr = 0, rd = 0, start = 0, detect_start = 0;
   logic [7:0] addr = 0, wr_addr_low = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] blocks_left;
   logic [2:0] eq_stage_en, drive_level;
   logic rd_outstanding, second_read_ok, frag_here, detect_sample, detect_busy;
   int n_mismatch = 0, num_checks = 0, n;
   int thr [8] = '{0, 1, 2, 4, 8, 8, 8, 8};
   int us [4] = '{1, 2, 4, 5};
   always #20 clk = ~clk;
   upstream_txn_phy_control upstream_txn_phy_control_inst (.*);
   link_partner link_partner_inst (.*);
   task automatic chk(logic [31:0] g, logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   // one-cycle strobe; a read compares the data in the following cycle
   task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'h0;
      rd <= 1'h0;
      #1 if (!w) chk(rdata, d);
   endtask : acc
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   // tests; inputs change by nba at rising edges, outputs read 1 ns later
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'h1;
      repeat (3) @(posedge clk);
      acc(0, 8'h68, 32'h8000_0000);
      acc(0, 8'h6c, 32'h09b4_3612);
      acc(1, 8'h68, '1);
      acc(1, 8'h6c, '1);
      acc(1, 8'h70, '1);
      acc(0, 8'h68, 32'hf800_0000);
      acc(0, 8'h6c, 32'h7fff_ffff);
      chk(32'(drive_level), 32'h0000_0000);
      chk(32'(eq_stage_en), 32'h0000_0007);
      acc(0, 8'h70, 32'h0000_0000);
      $display("registers done");
      for (int c = 0; c < 8; c++) begin
         acc(1, 8'h68, {2'h2, c[2:0], 27'h0});
         @(posedge clk) start <= 1'h1;
         @(posedge clk) start <= 1'h0;
         repeat (2) @(posedge clk);
         #1;
         for (n = 0; n < 200 && second_read_ok !== 1'h1; n++) #40;
         chk(32'(blocks_left), thr[c]);
      end
      $display("pacing done");
      for (int f = 0; f < 4; f++) begin
         acc(1, 8'h68, {f[1:0], 30'h0});
         for (int a = 32; a < 256; a += 32) begin
            @(posedge clk) wr_addr_low <= a[7:0];
            repeat (2) @(posedge clk);
            #1;
            chk(32'(frag_here), 32'(a % (f > 1 ? 128 : 32 << f) == 0));
         end
      end
      $display("fragment done");
      for (int t = 0; t < 4; t++) begin
         acc(1, 8'h6c, {1'h0, t[2:0], 22'h0, t[2:0], t[2:0]});
         acc(0, 8'h6c, {1'h0, t[2:0], 22'h0, t[2:0], t[2:0]});
         chk(32'(eq_stage_en), t);
         chk(32'(drive_level), t);
         @(posedge clk) detect_start <= 1'h1;
         @(posedge clk) detect_start <= 1'h0;
         #1;
         for (n = 0; n < 999 && detect_sample !== 1'h1; n++) #40;
         chk(32'(n >= us[t] * 25 && n < us[t] * 25 + 3), 1);
      end
      $display("detect done");
      stop_test();
   end
   // cut a hang short; the tests need under 3k cycles
   initial begin
      #800_000;
      n_mismatch++;
      stop_test();
   end
endmodule : tb

// ---- upc_chk_sva.sv ----
// port checker for the pacing and phy tuning bank
`timescale 1ns/1ps
module upc_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic [3:0] blocks_left,
   input wire logic rd_outstanding,
   input wire logic second_read_ok,
   input wire logic [2:0] eq_stage_en,
   input wire logic [2:0] drive_level,
   input wire logic detect_sample,
   input wire logic detect_busy
);
   // waits of four cycles cover the two-stage reset release
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [11:0] busy_run = 12'h000;
   // length of the current busy stretch; longest legal wait is 1250 cycles
   always_ff @(posedge clk) begin
      busy_run <= detect_busy ? busy_run + 12'h001 : 12'h000;
   end
   property p_rsv_pace; rd && addr == 8'h68 |=> rdata[26:0] == 27'h0; endproperty
   a_rsv_pace: assert property (p_rsv_pace) else $error("pacing spare bits set");
   property p_rsv_phy; rd && addr == 8'h6c |=> !rdata[31]; endproperty
   a_rsv_phy: assert property (p_rsv_phy) else $error("phy spare bit set");
   property p_idle_ok; !rd_outstanding [*4] |-> second_read_ok; endproperty
   a_idle_ok: assert property (p_idle_ok) else $error("idle read held");
   property p_far_wait; (rd_outstanding && blocks_left > 4'h8) [*2] |-> !second_read_ok; endproperty
   a_far_wait: assert property (p_far_wait) else $error("read sent too early");
   property p_zero_ok; (rd_outstanding && blocks_left == 4'h0) [*4] |-> second_read_ok; endproperty
   a_zero_ok: assert property (p_zero_ok) else $error("read held at zero");
   property p_tuning; rd && addr == 8'h6c ##1 !wr |=> eq_stage_en == $past(rdata[5:3]) &&
      drive_level == ($past(rdata[30:28]) > 3'h4 ? 3'h0 : $past(rdata[30:28])); endproperty
   a_tuning: assert property (p_tuning) else $error("tuning outputs wrong");
   property p_det_len; $rose(detect_busy) |-> detect_busy [*8]; endproperty
   a_det_len: assert property (p_det_len) else $error("detect wait wrong");
   property p_det_max; detect_busy |-> busy_run < 12'd1250; endproperty
   a_det_max: assert property (p_det_max) else $error("detect wait too long");
   property p_det_fall; $fell(detect_busy) |-> detect_sample; endproperty
   a_det_fall: assert property (p_det_fall) else $error("detect end without sample");
   property p_det_end; detect_sample |=> !detect_busy ##1 !detect_sample; endproperty
   a_det_end: assert property (p_det_end) else $error("detect end wrong");
endmodule : upc_chk
bind upstream_txn_phy_control upc_chk upc_chk_inst (.*);

// ---- upstream_txn_phy_control.sv ----
// pacing/fragment register, phy tuning register and derived control outputs
//
// Summary of operation
// - three-bit read pacing field governs issuing a second read from a channel.
// - code 000 holds the second read until all completion data arrived.
// - code 001 allows the second read once one aligned block remains.
// - code 010 allows the second read once two aligned blocks remain.
// - code 011 allows the second read once four aligned blocks remain.
// - top bit set allows the second read once eight aligned blocks remain.
// - fragment code 00 splits writes at 32-byte boundaries.
// - fragment code 01 splits writes at 64-byte boundaries.
// - fragment top bit set splits at 128 bytes; reset value is 10.
// - detect timer codes give 1,2,4,5,10,20,40,50 us; reset gives 4 us.
// - equalization bits 0,1,2 enable stages 0,1,2 independently.
// - drive level 000 nominal, 001-100 margins; other codes are reserved.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "pacing_cfg.svh"
module upstream_txn_phy_control (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [3:0] blocks_left,
   input wire logic rd_outstanding,
   output logic second_read_ok,
   input wire logic [7:0] wr_addr_low,
   output logic frag_here,
   output logic [2:0] eq_stage_en,
   output logic [2:0] drive_level,
   input wire logic detect_start,
   output logic detect_sample,
   output logic detect_busy
);
   logic rst_m;
   logic rst_s;
   pacing_pkg::pacing_t pace;
   pacing_pkg::pacing_t next_pace;
   pacing_pkg::phy_t phy;
   pacing_pkg::phy_t next_phy;
   logic [31:0] next_rdata;
   logic next_second_read_ok;
   logic next_frag_here;
   logic [2:0] next_drive_level;
   pacing_pkg::detect_state_t state;
   pacing_pkg::detect_state_t next_state;
   logic [10:0] count;
   logic [10:0] next_count;
   logic next_detect_sample;

   // cycles for a wait of the given number of microseconds
   function automatic logic [10:0] us_cycles(input logic [2:0] code);
      logic [5:0] us;
      us = 6'h00;
      case (code)
         3'h0: us = 6'h01;
         3'h1: us = 6'h02;
         3'h2: us = 6'h04;
         3'h3: us = 6'h05;
         3'h4: us = 6'h0a;
         3'h5: us = 6'h14;
         3'h6: us = 6'h28;
         default: us = 6'h32;
      endcase
      us_cycles = 11'(us * `CLK_MHZ);
   endfunction : us_cycles

   // reset released through two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_m <= 1'b0;
         rst_s <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_s <= rst_m;
      end
   end

   // register writes and read mux; reserved bits are simply not stored
   always_comb begin
      next_pace = pace;
      next_phy = phy;
      next_rdata = 32'h0000_0000;
      if (wr && addr == `OFS_PACING) begin
         next_pace.rd_pace = wdata[`RD_PACE_LSB +: 3];
         next_pace.wr_frag = wdata[`WR_FRAG_LSB +: 2];
      end
      if (wr && addr == `OFS_PHY) begin
         next_phy.timer = wdata[`TIMER_LSB +: 3];
         next_phy.eq = wdata[`EQ_LSB +: 4];
         next_phy.cr_en = wdata[`CR_EN_BIT];
         next_phy.cr_gain = wdata[`CR_GAIN_LSB +: 2];
         next_phy.sigdet = wdata[`SIGDET_LSB +: 2];
         next_phy.cr_filt = wdata[`CR_FILT_LSB +: 2];
         next_phy.deemph_en = wdata[`DEEMPH_EN_LSB +: 4];
         next_phy.deemph_base = wdata[`DEEMPH_BASE_LSB +: 5];
         next_phy.level_base = wdata[`LEVEL_BASE_LSB +: 5];
         next_phy.drive = wdata[`DRIVE_LSB +: 3];
      end
      // unmapped addresses and reserved bits answer zero
      if (rd && addr == `OFS_PACING) begin
         next_rdata[`RD_PACE_LSB +: 3] = pace.rd_pace;
         next_rdata[`WR_FRAG_LSB +: 2] = pace.wr_frag;
      end
      if (rd && addr == `OFS_PHY) begin
         next_rdata[30:0] = phy;
      end
   end

   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         pace <= '{`RST_RD_PACE, `RST_WR_FRAG};
         phy <= '{`RST_DRIVE, `RST_LEVEL_BASE, `RST_DEEMPH_BASE, `RST_DEEMPH_EN,
            `RST_CR_FILT, `RST_SIGDET, `RST_CR_GAIN, `RST_CR_EN, `RST_EQ, `RST_TIMER};
         rdata <= 32'h0000_0000;
      end else begin
         pace <= next_pace;
         phy <= next_phy;
         rdata <= next_rdata;
      end
   end

   // pacing, fragmenting and phy outputs
   always_comb begin
      next_second_read_ok = !rd_outstanding;
      if (rd_outstanding) begin
         if (pace.rd_pace[2]) next_second_read_ok = blocks_left <= 4'h8;
         else begin
            case (pace.rd_pace[1:0])
               2'h0: next_second_read_ok = blocks_left == 4'h0;
               2'h1: next_second_read_ok = blocks_left <= 4'h1;
               2'h2: next_second_read_ok = blocks_left <= 4'h2;
               default: next_second_read_ok = blocks_left <= 4'h4;
            endcase
         end
      end
      // flags the next byte as the first of a new aligned boundary
      if (pace.wr_frag[1]) next_frag_here = wr_addr_low[6:0] == 7'h00;
      else if (pace.wr_frag[0]) next_frag_here = wr_addr_low[5:0] == 6'h00;
      else next_frag_here = wr_addr_low[4:0] == 5'h00;
      // reserved drive codes fall back to nominal rather than misdrive
      next_drive_level = (phy.drive > `DRIVE_MAX) ? 3'h0 : phy.drive;
   end

   // receiver-detect wait timer
   always_comb begin
      next_state = state;
      next_count = count;
      next_detect_sample = 1'b0;
      case (state)
         pacing_pkg::idle: begin
            if (detect_start) begin
               next_state = pacing_pkg::waiting;
               next_count = us_cycles(phy.timer);
            end
         end
         pacing_pkg::waiting: begin
            // wait the full count after the accepting edge, never one short
            if (count == 11'h000) begin
               next_state = pacing_pkg::done;
               next_detect_sample = 1'b1;
            end else next_count = count - 11'h001;
         end
         pacing_pkg::done: next_state = pacing_pkg::idle;
         default: next_state = pacing_pkg::idle;
      endcase
   end

   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         second_read_ok <= 1'b0;
         frag_here <= 1'b0;
         eq_stage_en <= 3'h0;
         drive_level <= 3'h0;
         state <= pacing_pkg::idle;
         count <= 11'h000;
         detect_sample <= 1'b0;
         detect_busy <= 1'b0;
      end else begin
         second_read_ok <= next_second_read_ok;
         frag_here <= next_frag_here;
         eq_stage_en <= phy.eq[2:0];
         drive_level <= next_drive_level;
         state <= next_state;
         count <= next_count;
         detect_sample <= next_detect_sample;
         detect_busy <= next_state == pacing_pkg::waiting;
      end
   end
endmodule : upstream_txn_phy_control
